// file: bench/wake_event_indication_ctrl_test.sv
// Self-checking bench: host and device joined by the link interface.
// Assumes a 50 MHz clock and Wishbone access to the host end.
`timescale 1ns/10ps
module wake_event_indication_ctrl_test;
	import wec_pkg::*;
	localparam int PULSE = 20;
	logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat_w, wb_dat_r, q, st, cfg;
	logic energy_src, lan_src, low_power, kind, pol;
	logic ev_out, ev_oe_n, ev_int, wake;
	int n_fail, tests_run, n_wake, cyc_cnt, n, t, i;
	wec_if link ();
	wec_device #(.PULSE_CYCLES(PULSE)) i_wec_device (.clk_i(clk_i),
		.rst_i(rst_i), .bus(link), .energy_src_i(energy_src),
		.lan_src_i(lan_src), .low_power_i(low_power),
		.power_event_output_o(ev_out), .power_event_oe_n_o(ev_oe_n),
		.power_event_interrupt_o(ev_int), .wake_request_o(wake));
	wec_host i_wec_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
		.wb_ack_o(wb_ack), .bus(link));
	wec_link_properties #(.PULSE_CYCLES(PULSE)) i_wec_link_properties (
		.clk_i(clk_i), .rst_i(rst_i), .req(link.req), .we(link.we),
		.addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
		.ack(link.ack), .energy_src_i(energy_src),
		.low_power_i(low_power), .power_event_output_o(ev_out),
		.power_event_oe_n_o(ev_oe_n), .power_event_interrupt_o(ev_int),
		.wake_request_o(wake));
	// ---------------------------------------------------------------
	// Clock, timeout and wake pulse monitor
	// ---------------------------------------------------------------
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (wake === 1'b1) begin
			n_wake <= n_wake + 1;
		end
		if (cyc_cnt == 30000) begin
			n_fail++;
			end_sim();
		end
	end
	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk_word(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_dat_w <= d;
		wb_sel <= 4'hF;
		do @(posedge clk_i); while (wb_ack !== 1'b1);
		r = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic lnk(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		logic [31:0] s;
		if (w) wb(1'b1, WB_WDATA_OFS, d, s);
		wb(1'b1, WB_CMD_OFS, {23'h0, w, a}, s);
		do wb(1'b0, WB_STAT_OFS, 32'h0, s); while (s[0] === 1'b1);
		st = s;
		r = s;
		if (!w) wb(1'b0, WB_RDATA_OFS, 32'h0, r);
	endtask
	task automatic wait_ready();
		t = 0;
		do begin
			lnk(1'b0, POWER_CTRL_OFS, 32'h0, q);
			t++;
		end while (q[0] !== 1'b1 && t < 40);
	endtask
	task automatic expect_pmt(input string nm, input logic [1:0] s);
		lnk(1'b0, POWER_CTRL_OFS, 32'h0, q);
		chk_word(nm, cfg | 32'h1 | {26'h0, s, 4'h0}, q);
	endtask
	// ---------------------------------------------------------------
	// Test sequence
	// ---------------------------------------------------------------
	initial begin
		clk_i = 0; rst_i = 1; wb_cyc = 0; wb_stb = 0; wb_we = 0;
		wb_adr = 0; wb_sel = 0; wb_dat_w = 0; energy_src = 0;
		lan_src = 0; low_power = 0; n_fail = 0; tests_run = 0;
		n_wake = 0; cyc_cnt = 0; cfg = 0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		lnk(1'b0, BYTE_TEST_OFS, 32'h0, q);
		chk_bit("early_refused", 1'b1, st[1]);
		lnk(1'b0, CONFIG_OFS, 32'h0, q);
		chk_word("hardware_config_reg", CONFIG_VAL, q);
		lnk(1'b0, POWER_CTRL_OFS, 32'h0, q);
		chk_bit("ready_early", 1'b0, q[0]);
		wait_ready();
		chk_word("pmt_reset", 32'h1, q);
		wb(1'b0, 8'h10, 32'h0, q);
		chk_word("unmapped", 32'h0, q);
		cfg = 32'h344;
		lnk(1'b1, POWER_CTRL_OFS, cfg, q);
		energy_src <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk_bit("int_no_en", 1'b1, ev_int);
		chk_bit("oe_no_en", 1'b1, ev_oe_n);
		expect_pmt("st_energy", STATUS_ENERGY);
		lan_src <= 1'b1;
		repeat (8) @(posedge clk_i);
		expect_pmt("st_both", 2'h3);
		lnk(1'b1, POWER_CTRL_OFS, cfg | 32'h30, q);
		expect_pmt("st_src_high", 2'h3);
		energy_src <= 1'b0;
		lan_src <= 1'b0;
		repeat (6) @(posedge clk_i);
		lnk(1'b1, POWER_CTRL_OFS, cfg | 32'h10, q);
		expect_pmt("st_frame", STATUS_FRAME);
		lnk(1'b1, POWER_CTRL_OFS, cfg | 32'h20, q);
		expect_pmt("st_none", STATUS_NONE);
		energy_src <= 1'b1;
		repeat (8) @(posedge clk_i);
		energy_src <= 1'b0;
		low_power <= 1'b1;
		repeat (6) @(posedge clk_i);
		lnk(1'b1, POWER_CTRL_OFS, cfg | 32'h10, q);
		lnk(1'b1, BYTE_TEST_OFS, 32'h0, q);
		repeat (3) @(posedge clk_i);
		chk_word("wake_pulses", 32'h1, n_wake);
		low_power <= 1'b0;
		wait_ready();
		expect_pmt("st_kept", STATUS_ENERGY);
		lnk(1'b1, POWER_CTRL_OFS, cfg | 32'h10, q);
		expect_pmt("st_cleared", STATUS_NONE);
		for (i = 0; i < 3; i++) begin
			kind = (i != 2);
			pol = (i != 0);
			cfg = 32'h102 | {25'h0, kind, 3'h0, pol, 2'h0};
			lnk(1'b1, POWER_CTRL_OFS, cfg, q);
			energy_src <= 1'b1;
			repeat (8) @(posedge clk_i);
			chk_bit("out_act", kind & pol, ev_out);
			chk_bit("oe_act", 1'b0, ev_oe_n);
			energy_src <= 1'b0;
			repeat (6) @(posedge clk_i);
			lnk(1'b1, POWER_CTRL_OFS, cfg | 32'h10, q);
			repeat (3) @(posedge clk_i);
			chk_bit("out_idle", kind & !pol, ev_out);
			chk_bit("oe_idle", !kind, ev_oe_n);
		end
		cfg = 32'h14E;
		lnk(1'b1, POWER_CTRL_OFS, cfg, q);
		energy_src <= 1'b1;
		n = 0;
		t = 0;
		while (ev_out !== 1'b1 && t < 20) begin
			@(posedge clk_i);
			t++;
		end
		while (ev_out === 1'b1 && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		energy_src <= 1'b0;
		chk_word("pulse_len", PULSE, n);
		expect_pmt("st_after_pulse", STATUS_ENERGY);
		end_sim();
	end
endmodule // wake_event_indication_ctrl_test

// file: bench/wec_link_properties.sv
// Concurrent checks on the host to device link and the event pins.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module wec_link_properties
	import wec_pkg::*;
#(
	parameter int PULSE_CYCLES = 20
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic [31:0] rdata,
	input wire logic ack,
	input wire logic energy_src_i,
	input wire logic low_power_i,
	input wire logic power_event_output_o,
	input wire logic power_event_oe_n_o,
	input wire logic power_event_interrupt_o,
	input wire logic wake_request_o
);
	// ---------------------------------------------------------------
	// Shadow of the control bits and pulse length counter
	// ---------------------------------------------------------------
	logic [9:0] cfg_reg;
	logic [9:0] cfg_next;
	logic [15:0] run_reg;
	logic [15:0] run_next;
	always_comb begin
		cfg_next = cfg_reg;
		if (req && !ack && we && addr == POWER_CTRL_OFS) begin
			cfg_next = wdata[9:0];
		end
		run_next = 16'h0;
		if (power_event_output_o && cfg_reg[PULSE_SEL_BIT] &&
			cfg_reg[BUF_KIND_BIT] && cfg_reg[EVT_POL_BIT]) begin
			run_next = run_reg + 16'h1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_reg <= 10'h0;
			run_reg <= 16'h0;
		end else begin
			cfg_reg <= cfg_next;
			run_reg <= run_next;
		end
	end
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_take_read;
		req && !ack && !we;
	endsequence
	sequence s_byte_wr_low;
		req && !ack && we && addr == BYTE_TEST_OFS && low_power_i;
	endsequence
	property p_ack_once;
		req && !ack |=> ack;
	endproperty
	property p_ack_pulse;
		ack |=> !ack;
	endproperty
	property p_hwcfg;
		s_take_read ##0 addr == CONFIG_OFS |=> ack && rdata == CONFIG_VAL;
	endproperty
	property p_en_off;
		(!cfg_reg[EVT_EN_BIT])[*3] |-> power_event_oe_n_o;
	endproperty
	property p_od;
		(!cfg_reg[BUF_KIND_BIT])[*3] |-> !power_event_output_o;
	endproperty
	property p_int_rise;
		$rose(energy_src_i) && cfg_reg[ENERGY_EN_BIT]
			|-> ##[3:6] power_event_interrupt_o;
	endproperty
	property p_static;
		(power_event_interrupt_o && cfg_reg[EVT_EN_BIT] &&
			cfg_reg[BUF_KIND_BIT] && cfg_reg[EVT_POL_BIT] &&
			!cfg_reg[PULSE_SEL_BIT])[*3] |-> power_event_output_o;
	endproperty
	property p_pulse_len;
		run_reg <= 16'(PULSE_CYCLES);
	endproperty
	property p_wake;
		s_byte_wr_low |-> ##[1:2] wake_request_o;
	endproperty
	property p_rst;
		$fell(rst_i) |-> power_event_oe_n_o && !power_event_interrupt_o;
	endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("link request not answered in one cycle");
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("link answer longer than one cycle");
	a_hwcfg: assert property (p_hwcfg)
		else $error("config register read wrong");
	a_en_off: assert property (p_en_off)
		else $error("event pin driven while disabled");
	a_od: assert property (p_od)
		else $error("open drain output not low");
	a_int_rise: assert property (p_int_rise)
		else $error("interrupt missing after energy event");
	a_static: assert property (p_static)
		else $error("static event output not active");
	a_pulse_len: assert property (p_pulse_len)
		else $error("event pulse too long");
	a_wake: assert property (p_wake)
		else $error("wake request missing");
	a_rst: assert property (p_rst)
		else $error("event outputs not idle after reset");
endmodule // wec_link_properties

// file: src/wec_device.sv
// Functional notes
// - Status 0 none, 1 energy, 2 frame
// - Both causes seen shows three
// - Status bits clear by writing one
// - Clears ignored unless ready and normal
// - Bit clears only when sources cleared
// - Pulse mode drives one 50 ms pulse
// - Static mode holds output active
// - Status clear or enable clear deasserts
// - Polarity bit selects output active level
// - Open-drain ignores polarity, active low
// - Output driven only while enabled
// - Enable leaves internal interrupt alone
// - Ready flag sets after stabilising
// - Control register readable in every mode
// - Host avoids other addresses before ready
// - Before ready, only two registers read
// - Host soft-resets only after ready
// - Mode zero is the normal state
// - Buffer bit: clear open-drain, set push-pull
// - Byte test write wakes the device
// - Enabled wake source raises interrupt
//
// Device end: power management control register and event output.
// Assumes the event sources arrive asynchronously from the pins.
`timescale 1ns/10ps
module wec_device #(
	parameter int PULSE_CYCLES = wec_pkg::PULSE_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	wec_if.device bus,
	input wire logic energy_src_i,
	input wire logic lan_src_i,
	input wire logic low_power_i,
	output logic power_event_output_o,
	output logic power_event_oe_n_o,
	output logic power_event_interrupt_o,
	output logic wake_request_o
);
	import wec_pkg::*;

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	localparam int SW = $clog2(STABLE_CYCLES + 1);
	localparam logic [SW-1:0] STABLE_LAST = SW'(STABLE_CYCLES - 1);

	logic [1:0] src_meta_reg;
	logic [1:0] src_sync_reg;
	logic [1:0] src_prev_reg;
	logic [1:0] event_hit;

	logic evt_en_reg, evt_en_next;
	logic pol_reg, pol_next;
	logic pulse_sel_reg, pulse_sel_next;
	logic buf_kind_reg, buf_kind_next;
	logic energy_wake_enable_reg, energy_wake_enable_next;
	logic lan_wake_enable_reg, lan_wake_enable_next;
	logic [1:0] status_reg, status_next;
	logic [1:0] status_clr;

	logic ready_reg, ready_next;
	logic [SW-1:0] stab_reg, stab_next;

	logic ack_reg, ack_next;
	logic [31:0] rdata_reg, rdata_next;
	logic take;
	logic pmt_wr;
	logic wake_reg, wake_next;

	logic pulse_start;
	logic pulse_cancel;
	logic pulse_busy;
	logic active;
	logic out_reg, out_next;
	logic oe_n_reg, oe_n_next;
	logic irq_reg, irq_next;

	// ---------------------------------------------------------------
	// Source synchronisers and edge detect
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_meta_reg <= 2'h0;
			src_sync_reg <= 2'h0;
			src_prev_reg <= 2'h0;
		end else begin
			src_meta_reg <= {lan_src_i, energy_src_i};
			src_sync_reg <= src_meta_reg;
			src_prev_reg <= src_sync_reg;
		end
	end

	// Only enabled sources count as wake events.
	assign event_hit = src_sync_reg & ~src_prev_reg
		& {lan_wake_enable_reg, energy_wake_enable_reg};

	// ---------------------------------------------------------------
	// Bus slave
	// ---------------------------------------------------------------
	assign take = bus.req && !ack_reg;
	assign pmt_wr = take && bus.we && (bus.addr == POWER_CTRL_OFS);

	always_comb begin
		ack_next = take;
		rdata_next = rdata_reg;
		wake_next = 1'b0;
		if (take && !bus.we) begin
			case (bus.addr)
				POWER_CTRL_OFS: begin
					rdata_next = 32'h00000000;
					rdata_next[LAN_EN_BIT] = lan_wake_enable_reg;
					rdata_next[ENERGY_EN_BIT] = energy_wake_enable_reg;
					rdata_next[BUF_KIND_BIT] = buf_kind_reg;
					rdata_next[STATUS_LSB+1:STATUS_LSB] = status_reg;
					rdata_next[PULSE_SEL_BIT] = pulse_sel_reg;
					rdata_next[EVT_POL_BIT] = pol_reg;
					rdata_next[EVT_EN_BIT] = evt_en_reg;
					rdata_next[READY_BIT] = ready_reg;
				end
				CONFIG_OFS: begin
					rdata_next = CONFIG_VAL;
				end
				BYTE_TEST_OFS: begin
					rdata_next = BYTE_TEST_VAL;
				end
				default: begin
					rdata_next = 32'h00000000;
				end
			endcase
		end
		if (take && bus.we && bus.addr == BYTE_TEST_OFS
			&& low_power_i) begin
			wake_next = 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Control register
	// ---------------------------------------------------------------
	always_comb begin
		evt_en_next = evt_en_reg;
		pol_next = pol_reg;
		pulse_sel_next = pulse_sel_reg;
		buf_kind_next = buf_kind_reg;
		energy_wake_enable_next = energy_wake_enable_reg;
		lan_wake_enable_next = lan_wake_enable_reg;
		status_clr = 2'h0;
		if (pmt_wr) begin
			evt_en_next = bus.wdata[EVT_EN_BIT];
			pol_next = bus.wdata[EVT_POL_BIT];
			pulse_sel_next = bus.wdata[PULSE_SEL_BIT];
			buf_kind_next = bus.wdata[BUF_KIND_BIT];
			energy_wake_enable_next = bus.wdata[ENERGY_EN_BIT];
			lan_wake_enable_next = bus.wdata[LAN_EN_BIT];
			if (ready_reg && !low_power_i) begin
				status_clr = bus.wdata[STATUS_LSB+1:STATUS_LSB]
					& ~src_sync_reg;
			end
		end
		// A new event in the clearing cycle wins over the clear.
		status_next = (status_reg & ~status_clr)
			| event_hit;
	end

	// ---------------------------------------------------------------
	// Ready flag
	// ---------------------------------------------------------------
	always_comb begin
		ready_next = ready_reg;
		stab_next = stab_reg;
		if (low_power_i) begin
			ready_next = 1'b0;
			stab_next = '0;
		end else if (!ready_reg) begin
			if (stab_reg == STABLE_LAST) begin
				ready_next = 1'b1;
			end
			stab_next = stab_reg + SW'(1);
		end
	end

	// ---------------------------------------------------------------
	// Event output
	// ---------------------------------------------------------------
	assign pulse_start = pulse_sel_reg && evt_en_reg
		&& (event_hit != 2'h0);
	assign pulse_cancel = !evt_en_reg
		|| (status_reg != STATUS_NONE
		&& status_next == STATUS_NONE);

	wec_pulse_timer #(
		.COUNT(PULSE_CYCLES)
	) i_wec_pulse_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(pulse_start),
		.cancel_i(pulse_cancel),
		.busy_o(pulse_busy)
	);

	always_comb begin
		if (pulse_sel_reg) begin
			active = pulse_busy;
		end else begin
			active = evt_en_reg && status_reg != STATUS_NONE;
		end
		if (!buf_kind_reg) begin
			out_next = 1'b0;
			oe_n_next = !(active && evt_en_reg);
		end else begin
			out_next = pol_reg ? active : !active;
			oe_n_next = !evt_en_reg;
		end
		// The interrupt ignores the output enable.
		irq_next = status_next != STATUS_NONE;
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_en_reg <= CTRL_BIT_RST;
			pol_reg <= CTRL_BIT_RST;
			pulse_sel_reg <= CTRL_BIT_RST;
			buf_kind_reg <= CTRL_BIT_RST;
			energy_wake_enable_reg <= CTRL_BIT_RST;
			lan_wake_enable_reg <= CTRL_BIT_RST;
			status_reg <= STATUS_NONE;
			ready_reg <= 1'b0;
			stab_reg <= '0;
			ack_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			wake_reg <= 1'b0;
			out_reg <= 1'b0;
			oe_n_reg <= 1'b1;
			irq_reg <= 1'b0;
		end else begin
			evt_en_reg <= evt_en_next;
			pol_reg <= pol_next;
			pulse_sel_reg <= pulse_sel_next;
			buf_kind_reg <= buf_kind_next;
			energy_wake_enable_reg <= energy_wake_enable_next;
			lan_wake_enable_reg <= lan_wake_enable_next;
			status_reg <= status_next;
			ready_reg <= ready_next;
			stab_reg <= stab_next;
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			wake_reg <= wake_next;
			out_reg <= out_next;
			oe_n_reg <= oe_n_next;
			irq_reg <= irq_next;
		end
	end

	assign bus.ack = ack_reg;
	assign bus.rdata = rdata_reg;
	assign power_event_output_o = out_reg;
	assign power_event_oe_n_o = oe_n_reg;
	assign power_event_interrupt_o = irq_reg;
	assign wake_request_o = wake_reg;
endmodule // wec_device

// file: src/wec_host.sv
// Host end: takes commands over classic Wishbone and runs them
// as single accesses on the device link, guarding the ready rules.
// Assumes Wishbone and the link share clk_i.
`timescale 1ns/10ps
module wec_host (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	wec_if.host bus
);
	import wec_pkg::*;

	typedef enum logic [1:0] {H_IDLE, H_ACCESS, H_GAP} wec_state_e;

	wec_state_e st_reg, st_next;
	logic ack_reg, ack_next;
	logic [31:0] dat_reg, dat_next;
	logic [7:0] addr_reg, addr_next;
	logic we_reg, we_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [31:0] rdata_reg, rdata_next;
	logic refused_reg, refused_next;
	logic ready_seen_reg, ready_seen_next;
	logic req_reg, req_next;
	logic wb_take;
	logic allowed;

	// ---------------------------------------------------------------
	// Command checks
	// ---------------------------------------------------------------
	assign wb_take = wb_cyc_i && wb_stb_i && !ack_reg;

	always_comb begin
		// Before ready only the two readable registers and the wake
		// write are legal; a soft reset waits for ready as well.
		allowed = ready_seen_reg
			|| (!wb_dat_i[CMD_WRITE_BIT]
			&& (wb_dat_i[7:0] == POWER_CTRL_OFS
			|| wb_dat_i[7:0] == CONFIG_OFS))
			|| (wb_dat_i[CMD_WRITE_BIT]
			&& wb_dat_i[7:0] == BYTE_TEST_OFS);
	end

	// ---------------------------------------------------------------
	// Wishbone slave and link sequencer
	// ---------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		ack_next = wb_take;
		dat_next = dat_reg;
		addr_next = addr_reg;
		we_next = we_reg;
		wdata_next = wdata_reg;
		rdata_next = rdata_reg;
		refused_next = refused_reg;
		ready_seen_next = ready_seen_reg;
		req_next = req_reg;
		if (wb_take && wb_we_i) begin
			if (wb_adr_i == WB_WDATA_OFS) begin
				for (int i = 0; i < 4; i++) begin
					if (wb_sel_i[i]) begin
						wdata_next[i*8 +: 8] = wb_dat_i[i*8 +: 8];
					end
				end
			end else if (wb_adr_i == WB_CMD_OFS
				&& st_reg == H_IDLE) begin
				addr_next = wb_dat_i[7:0];
				we_next = wb_dat_i[CMD_WRITE_BIT];
				refused_next = !allowed;
				if (allowed) begin
					req_next = 1'b1;
					st_next = H_ACCESS;
				end
			end
		end
		if (wb_take && !wb_we_i) begin
			case (wb_adr_i)
				WB_CMD_OFS: dat_next = {23'h0, we_reg, addr_reg};
				WB_WDATA_OFS: dat_next = wdata_reg;
				WB_RDATA_OFS: dat_next = rdata_reg;
				WB_STAT_OFS: dat_next = {29'h0, ready_seen_reg,
					refused_reg, st_reg != H_IDLE};
				default: dat_next = 32'h00000000;
			endcase
		end
		case (st_reg)
			H_ACCESS: begin
				if (bus.ack) begin
					req_next = 1'b0;
					st_next = H_GAP;
					if (!we_reg) begin
						rdata_next = bus.rdata;
						if (addr_reg == POWER_CTRL_OFS) begin
							ready_seen_next = bus.rdata[READY_BIT];
						end
					end
				end
			end
			H_GAP: st_next = H_IDLE;
			default: st_next = st_next;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= H_IDLE;
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
			addr_reg <= 8'h00;
			we_reg <= 1'b0;
			wdata_reg <= 32'h00000000;
			rdata_reg <= 32'h00000000;
			refused_reg <= 1'b0;
			ready_seen_reg <= 1'b0;
			req_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			ack_reg <= ack_next;
			dat_reg <= dat_next;
			addr_reg <= addr_next;
			we_reg <= we_next;
			wdata_reg <= wdata_next;
			rdata_reg <= rdata_next;
			refused_reg <= refused_next;
			ready_seen_reg <= ready_seen_next;
			req_reg <= req_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign bus.req = req_reg;
	assign bus.we = we_reg;
	assign bus.addr = addr_reg;
	assign bus.wdata = wdata_reg;
endmodule // wec_host

// file: src/wec_if.sv
// SRAM-like register link between the host controller and the device.
// Both ends run on the same clock; the bench joins them.
`timescale 1ns/10ps
interface wec_if;
	logic req;
	logic we;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic ack;
	modport host (
		output req,
		output we,
		output addr,
		output wdata,
		input rdata,
		input ack
	);
	modport device (
		input req,
		input we,
		input addr,
		input wdata,
		output rdata,
		output ack
	);
endinterface

// file: src/wec_pkg.sv
// Constants shared by both ends of the wake event indication link.
// Assumes a 50 MHz core clock common to host and device.
package wec_pkg;
	// ---------------------------------------------------------------
	// Device register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] BYTE_TEST_OFS = 8'h64;
	localparam logic [7:0] CONFIG_OFS = 8'h74;
	localparam logic [7:0] POWER_CTRL_OFS = 8'h84;
	localparam logic [31:0] BYTE_TEST_VAL = 32'h87654321;
	localparam logic [31:0] CONFIG_VAL = 32'h00000000;
	// ---------------------------------------------------------------
	// Power management control fields
	// ---------------------------------------------------------------
	localparam int READY_BIT = 0;
	localparam int EVT_EN_BIT = 1;
	localparam int EVT_POL_BIT = 2;
	localparam int PULSE_SEL_BIT = 3;
	localparam int STATUS_LSB = 4;
	localparam int BUF_KIND_BIT = 6;
	localparam int ENERGY_EN_BIT = 8;
	localparam int LAN_EN_BIT = 9;
	localparam logic [1:0] STATUS_NONE = 2'h0;
	localparam logic [1:0] STATUS_ENERGY = 2'h1;
	localparam logic [1:0] STATUS_FRAME = 2'h2;
	localparam logic CTRL_BIT_RST = 1'h0;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 50000000;
	localparam int PULSE_MS = 50;
	localparam int PULSE_CYCLES = PULSE_MS * (CLK_HZ / 1000);
	localparam int STABLE_NS = 2000;
	localparam int STABLE_CYCLES =
		(STABLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	// ---------------------------------------------------------------
	// Host controller Wishbone offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] WB_CMD_OFS = 8'h00;
	localparam logic [7:0] WB_WDATA_OFS = 8'h04;
	localparam logic [7:0] WB_RDATA_OFS = 8'h08;
	localparam logic [7:0] WB_STAT_OFS = 8'h0C;
	localparam int CMD_WRITE_BIT = 8;
endpackage

// file: src/wec_pulse_timer.sv
// One-shot timer that stays busy for COUNT cycles after a start.
// Assumes start and cancel come from logic on the same clock.
`timescale 1ns/10ps
module wec_pulse_timer #(
	parameter int COUNT = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic cancel_i,
	output logic busy_o
);
	localparam int W = $clog2(COUNT + 1);
	localparam logic [W-1:0] LAST = W'(COUNT - 1);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic busy_reg;
	logic busy_next;

	always_comb begin
		cnt_next = cnt_reg;
		busy_next = busy_reg;
		if (cancel_i) begin
			busy_next = 1'b0;
			cnt_next = '0;
		end else if (start_i && !busy_reg) begin
			busy_next = 1'b1;
			cnt_next = '0;
		end else if (busy_reg) begin
			if (cnt_reg == LAST) begin
				busy_next = 1'b0;
			end
			cnt_next = cnt_reg + W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
			busy_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			busy_reg <= busy_next;
		end
	end

	assign busy_o = busy_reg;
endmodule // wec_pulse_timer
